// file: flash_timebase_and_options.sv
// Flash timebase divider register, option shadow and security state
// Overview of operation
// - Reset clears loaded flag bit 7; first divider write sets it
// - Erase and program are blocked until the loaded flag is set
// - Bit 6 selects bus clock or bus clock divided by eight
// - Flash clock is selected input divided by ratio field plus one
// - Each timing pulse lasts one flash clock; operations use whole pulses
// - Every reset copies the stored option byte into the shadow
// - Shadow bits 5 to 2 always read zero
// - Shadow is always readable; writes change nothing
// - With unlock allow clear, backdoor unlock is always rejected
// - Key values only count from user firmware, not the debug path
// - Eight matching key bytes in order unsecure until next reset
// - Shadow bit 6 set disables vector redirection
// - Only lock code 10 means unsecured; others are secured
// - While secured, unsecured sources cannot reach RAM or flash
// - Security state becomes unsecured after backdoor match or blank check; lock code bits stay unchanged
//
// Decided for this implementation: strobed register access and the address map.
module flash_timebase_and_options
  import flash_timebase_pkg::*;
#(
  parameter int ratio_bits = ratio_width,
  parameter int key_count = key_bytes
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Register port
  input wire logic [3:0] i_address,
  input wire logic [7:0] i_write_data,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic i_debug_access,
  output logic [7:0] o_read_data,
  // Nonvolatile sources
  input wire logic [7:0] i_stored_option_byte,
  input wire logic [63:0] i_stored_unlock_key,
  // Flash engine
  input wire logic i_op_request,
  input wire logic i_memory_request,
  input wire logic i_memory_unsecured_source,
  output logic o_op_allowed,
  output logic o_memory_grant,
  output logic o_flash_tick,
  output logic o_vector_redirect_off,
  output logic o_secured
);
  logic [7:0] flash_timebase_ctrl;
  logic [7:0] flash_option_shadow;
  logic load_pending;
  logic [2:0] key_index;
  logic key_good;
  logic backdoor_open;
  logic blank_pass;
  logic key_write;
  logic [7:0] expected_key;
  logic [7:0] next_read_data;

  function automatic logic is_unsecured(input logic [1:0] code);
    return code == unsecured_code;
  endfunction

  // Pulse divider
  flash_pulse_divider #(
    .ratio_bits(ratio_bits)
  ) divider (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_run(flash_timebase_ctrl[loaded_bit]),
    .i_prescale(flash_timebase_ctrl[prescale_bit]),
    .i_ratio(flash_timebase_ctrl[ratio_bits-1:0]),
    .o_tick(o_flash_tick)
  );

  // Divider register
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      flash_timebase_ctrl <= timebase_ctrl_reset;
    end else if (i_write && i_address == timebase_ctrl_offset) begin
      flash_timebase_ctrl[loaded_bit] <= 1'b1;
      flash_timebase_ctrl[prescale_bit] <= i_write_data[prescale_bit];
      flash_timebase_ctrl[ratio_bits-1:0] <= i_write_data[ratio_bits-1:0];
    end
  end

  // Option shadow loads once after reset release
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      flash_option_shadow <= option_shadow_reset;
      load_pending <= 1'b1;
    end else if (load_pending) begin
      flash_option_shadow <= i_stored_option_byte & option_used_mask;
      load_pending <= 1'b0;
    end
  end

  // Backdoor key comparison
  assign key_write = i_write && i_address == key_data_offset && !i_debug_access;
  assign expected_key = i_stored_unlock_key[8*(key_count-1-int'(key_index)) +: 8];

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      key_index <= key_index_reset;
      key_good <= 1'b1;
      backdoor_open <= 1'b0;
    end else if (key_write && flash_option_shadow[unlock_allow_bit]) begin
      if (key_index == 3'(key_count - 1)) begin
        backdoor_open <= backdoor_open || (key_good && i_write_data == expected_key);
        key_index <= key_index_reset;
        key_good <= 1'b1;
      end else begin
        key_good <= key_good && i_write_data == expected_key;
        key_index <= key_index + 3'h1;
      end
    end
  end

  // Blank check result
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      blank_pass <= 1'b0;
    end else if (i_write && i_address == blank_pass_offset && !i_debug_access
                 && i_write_data[0]) begin
      blank_pass <= 1'b1;
    end
  end

  // Outputs
  assign o_secured = !(is_unsecured(flash_option_shadow[1:0]) || backdoor_open
                       || blank_pass);
  assign o_op_allowed = i_op_request && flash_timebase_ctrl[loaded_bit];
  assign o_memory_grant = i_memory_request && (!o_secured || !i_memory_unsecured_source);
  assign o_vector_redirect_off = flash_option_shadow[redirect_off_bit];

  // Read mux; option shadow ignores writes
  always_comb begin
    next_read_data = 8'h00;
    unique case (i_address)
      timebase_ctrl_offset: next_read_data = flash_timebase_ctrl;
      option_shadow_offset: next_read_data = flash_option_shadow;
      lock_status_offset: next_read_data = {7'h00, o_secured};
      default: next_read_data = 8'h00;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_read_data <= 8'h00;
    end else if (i_read) begin
      o_read_data <= next_read_data;
    end else begin
      o_read_data <= 8'h00;
    end
  end

  // Checks
  property p_loaded_sticky;
    @(posedge i_clock) disable iff (i_reset)
      flash_timebase_ctrl[loaded_bit] |=> flash_timebase_ctrl[loaded_bit];
  endproperty
  a_loaded_sticky: assert property (p_loaded_sticky) else $error("Loaded flag cleared");

  property p_first_write;
    @(posedge i_clock) disable iff (i_reset)
      (i_write && i_address == timebase_ctrl_offset) |=> flash_timebase_ctrl[loaded_bit];
  endproperty
  a_first_write: assert property (p_first_write) else $error("Write did not set flag");

  property p_blocked;
    @(posedge i_clock) disable iff (i_reset)
      !flash_timebase_ctrl[loaded_bit] |-> !o_op_allowed;
  endproperty
  a_blocked: assert property (p_blocked) else $error("Operation allowed before load");

  property p_shadow_zero;
    @(posedge i_clock) disable iff (i_reset) flash_option_shadow[5:2] == 4'h0;
  endproperty
  a_shadow_zero: assert property (p_shadow_zero) else $error("Unused bits set");

  property p_shadow_stable;
    @(posedge i_clock) disable iff (i_reset)
      !load_pending |=> $stable(flash_option_shadow);
  endproperty
  a_shadow_stable: assert property (p_shadow_stable) else $error("Shadow changed");

  property p_shadow_load;
    @(posedge i_clock) disable iff (i_reset)
      (load_pending && !i_reset) |=>
        flash_option_shadow == ($past(i_stored_option_byte) & option_used_mask);
  endproperty
  a_shadow_load: assert property (p_shadow_load) else $error("Shadow not loaded");

  property p_no_backdoor;
    @(posedge i_clock) disable iff (i_reset)
      (!flash_option_shadow[unlock_allow_bit] && !backdoor_open) |=> !backdoor_open;
  endproperty
  a_no_backdoor: assert property (p_no_backdoor) else $error("Backdoor opened");

  property p_debug_key;
    @(posedge i_clock) disable iff (i_reset)
      (i_write && i_debug_access) |=> $stable(key_index);
  endproperty
  a_debug_key: assert property (p_debug_key) else $error("Debug key counted");

  property p_secure_block;
    @(posedge i_clock) disable iff (i_reset)
      (o_secured && i_memory_unsecured_source) |-> !o_memory_grant;
  endproperty
  a_secure_block: assert property (p_secure_block) else $error("Secured access granted");

  property p_redirect;
    @(posedge i_clock) disable iff (i_reset)
      o_vector_redirect_off == flash_option_shadow[redirect_off_bit];
  endproperty
  a_redirect: assert property (p_redirect) else $error("Redirect mismatch");

  property p_reset_clear;
    @(posedge i_clock) i_reset |=> !flash_timebase_ctrl[loaded_bit];
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("Loaded flag not cleared");

  property p_ctrl_written;
    @(posedge i_clock) disable iff (i_reset)
      (i_write && i_address == timebase_ctrl_offset) |=>
        (flash_timebase_ctrl[prescale_bit] == $past(i_write_data[prescale_bit])
         && flash_timebase_ctrl[ratio_bits-1:0] == $past(i_write_data[ratio_bits-1:0]));
  endproperty
  a_ctrl_written: assert property (p_ctrl_written) else $error("Divider fields wrong");

  property p_op_allowed;
    @(posedge i_clock) disable iff (i_reset)
      (flash_timebase_ctrl[loaded_bit] && i_op_request) |-> o_op_allowed;
  endproperty
  a_op_allowed: assert property (p_op_allowed) else $error("Operation refused after load");

  property p_tick_idle;
    @(posedge i_clock) disable iff (i_reset)
      !flash_timebase_ctrl[loaded_bit] |=> !o_flash_tick;
  endproperty
  a_tick_idle: assert property (p_tick_idle) else $error("Tick before load");

  property p_tick_single;
    @(posedge i_clock) disable iff (i_reset)
      (o_flash_tick && (flash_timebase_ctrl[prescale_bit]
                        || flash_timebase_ctrl[ratio_bits-1:0] != '0)) |=> !o_flash_tick;
  endproperty
  a_tick_single: assert property (p_tick_single) else $error("Tick longer than one cycle");

  property p_shadow_reset;
    @(posedge i_clock) i_reset |=> (flash_option_shadow == option_shadow_reset && load_pending);
  endproperty
  a_shadow_reset: assert property (p_shadow_reset) else $error("Shadow not reset");

  property p_backdoor_sticky;
    @(posedge i_clock) disable iff (i_reset)
      backdoor_open |=> backdoor_open;
  endproperty
  a_backdoor_sticky: assert property (p_backdoor_sticky) else $error("Backdoor closed");

  property p_unlock_reset;
    @(posedge i_clock)
      i_reset |=> (!backdoor_open && !blank_pass && key_index == key_index_reset);
  endproperty
  a_unlock_reset: assert property (p_unlock_reset) else $error("Unlock state kept");

  sequence s_key_step;
    key_write && flash_option_shadow[unlock_allow_bit];
  endsequence

  property p_key_advance;
    @(posedge i_clock) disable iff (i_reset)
      s_key_step ##0 (key_index != 3'(key_count - 1)) |=> key_index == $past(key_index) + 3'h1;
  endproperty
  a_key_advance: assert property (p_key_advance) else $error("Key index stuck");

  property p_key_wrap;
    @(posedge i_clock) disable iff (i_reset)
      s_key_step ##0 (key_index == 3'(key_count - 1)) |=> (key_index == key_index_reset && key_good);
  endproperty
  a_key_wrap: assert property (p_key_wrap) else $error("Key group not restarted");

  property p_key_miss;
    @(posedge i_clock) disable iff (i_reset)
      s_key_step ##0 (key_index != 3'(key_count - 1) && i_write_data != expected_key)
        |=> !key_good;
  endproperty
  a_key_miss: assert property (p_key_miss) else $error("Key miss not kept");

  property p_key_open;
    @(posedge i_clock) disable iff (i_reset)
      s_key_step ##0 (key_index == 3'(key_count - 1) && key_good && i_write_data == expected_key)
        |=> backdoor_open;
  endproperty
  a_key_open: assert property (p_key_open) else $error("Key match did not unlock");

  property p_key_locked;
    @(posedge i_clock) disable iff (i_reset)
      (i_write && i_address == key_data_offset && !flash_option_shadow[unlock_allow_bit])
        |=> ($stable(key_index) && $stable(backdoor_open));
  endproperty
  a_key_locked: assert property (p_key_locked) else $error("Key taken while barred");

  property p_blank_sticky;
    @(posedge i_clock) disable iff (i_reset)
      blank_pass |=> blank_pass;
  endproperty
  a_blank_sticky: assert property (p_blank_sticky) else $error("Blank pass lost");

  property p_blank_set;
    @(posedge i_clock) disable iff (i_reset)
      (i_write && i_address == blank_pass_offset && !i_debug_access && i_write_data[0])
        |=> !o_secured;
  endproperty
  a_blank_set: assert property (p_blank_set) else $error("Blank pass kept secure");

  property p_code_secured;
    @(posedge i_clock) disable iff (i_reset)
      (flash_option_shadow[1:0] != unsecured_code && !backdoor_open && !blank_pass)
        |-> o_secured;
  endproperty
  a_code_secured: assert property (p_code_secured) else $error("Secure code not secured");

  property p_code_unsecured;
    @(posedge i_clock) disable iff (i_reset)
      (flash_option_shadow[1:0] == unsecured_code) |-> !o_secured;
  endproperty
  a_code_unsecured: assert property (p_code_unsecured) else $error("Open code secured");

  property p_trusted_grant;
    @(posedge i_clock) disable iff (i_reset)
      (i_memory_request && !i_memory_unsecured_source) |-> o_memory_grant;
  endproperty
  a_trusted_grant: assert property (p_trusted_grant) else $error("Trusted access refused");

  property p_read_ctrl;
    @(posedge i_clock) disable iff (i_reset)
      (i_read && i_address == timebase_ctrl_offset) |=> o_read_data == $past(flash_timebase_ctrl);
  endproperty
  a_read_ctrl: assert property (p_read_ctrl) else $error("Divider read wrong");

  property p_read_shadow;
    @(posedge i_clock) disable iff (i_reset)
      (i_read && i_address == option_shadow_offset) |=> o_read_data == $past(flash_option_shadow);
  endproperty
  a_read_shadow: assert property (p_read_shadow) else $error("Shadow read wrong");

  property p_read_lock;
    @(posedge i_clock) disable iff (i_reset)
      (i_read && i_address == lock_status_offset) |=> o_read_data == {7'h00, $past(o_secured)};
  endproperty
  a_read_lock: assert property (p_read_lock) else $error("Lock status read wrong");
endmodule // flash_timebase_and_options

// file: flash_timebase_pkg.sv
// Package with register map, field positions and reset values for the flash timebase block
package flash_timebase_pkg;
  // Register offsets
  localparam logic [3:0] timebase_ctrl_offset = 4'h0;
  localparam logic [3:0] option_shadow_offset = 4'h1;
  localparam logic [3:0] key_data_offset = 4'h2;
  localparam logic [3:0] lock_status_offset = 4'h3;
  localparam logic [3:0] blank_pass_offset = 4'h4;
  // Timebase control fields
  localparam int loaded_bit = 7;
  localparam int prescale_bit = 6;
  localparam int ratio_width = 6;
  localparam int prescale_ratio = 8;
  localparam logic [7:0] timebase_ctrl_reset = 8'h00;
  // Option shadow fields
  localparam int unlock_allow_bit = 7;
  localparam int redirect_off_bit = 6;
  localparam logic [7:0] option_used_mask = 8'hC3;
  localparam logic [1:0] unsecured_code = 2'h2;
  localparam logic [7:0] option_shadow_reset = 8'h00;
  // Backdoor key
  localparam int key_bytes = 8;
  localparam logic [2:0] key_index_reset = 3'h0;
endpackage : flash_timebase_pkg

// file: flash_pulse_divider.sv
// Divider that makes one flash clock tick per prescaled ratio period
module flash_pulse_divider
  import flash_timebase_pkg::*;
#(
  parameter int ratio_bits = 6
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Settings
  input wire logic i_run,
  input wire logic i_prescale,
  input wire logic [ratio_bits-1:0] i_ratio,
  // Tick
  output logic o_tick
);
  logic [2:0] pre_count;
  logic [ratio_bits-1:0] div_count;
  logic pre_tick;

  assign pre_tick = !i_prescale || (pre_count == 3'(prescale_ratio - 1));

  always_ff @(posedge i_clock) begin
    if (i_reset || !i_run) begin
      pre_count <= 3'h0;
    end else if (pre_tick) begin
      pre_count <= 3'h0;
    end else begin
      pre_count <= pre_count + 3'h1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset || !i_run) begin
      div_count <= '0;
      o_tick <= 1'b0;
    end else if (pre_tick && div_count >= i_ratio) begin
      div_count <= '0;
      o_tick <= 1'b1;
    end else begin
      if (pre_tick) begin
        div_count <= div_count + 1'b1;
      end
      o_tick <= 1'b0;
    end
  end
endmodule // flash_pulse_divider

// file: tb.sv
// Self-checking bench for the flash timebase, option shadow and security logic
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin errors++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import flash_timebase_pkg::*;
  logic i_clock = 0, i_reset = 1, i_write = 0, i_read = 0, i_debug_access = 0;
  logic [3:0] i_address = 4'h0;
  logic [7:0] i_write_data = 8'h00, i_stored_option_byte = 8'hFE, o_read_data, rd_val;
  logic [63:0] i_stored_unlock_key = 64'h0123_4567_89AB_CDEF;
  logic i_op_request = 1, i_memory_request = 1, i_memory_unsecured_source = 1;
  logic o_op_allowed, o_memory_grant, o_flash_tick, o_vector_redirect_off, o_secured;
  int errors = 0, samples_checked = 0;
  flash_timebase_and_options flash_timebase_and_options_i (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_address(i_address),
    .i_write_data(i_write_data),
    .i_write(i_write),
    .i_read(i_read),
    .i_debug_access(i_debug_access),
    .o_read_data(o_read_data),
    .i_stored_option_byte(i_stored_option_byte),
    .i_stored_unlock_key(i_stored_unlock_key),
    .i_op_request(i_op_request),
    .i_memory_request(i_memory_request),
    .i_memory_unsecured_source(i_memory_unsecured_source),
    .o_op_allowed(o_op_allowed),
    .o_memory_grant(o_memory_grant),
    .o_flash_tick(o_flash_tick),
    .o_vector_redirect_off(o_vector_redirect_off),
    .o_secured(o_secured)
  );
  always #5 i_clock = ~i_clock;
  task conclude;
    $display("Mismatches %0d of %0d checks", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task rst(input logic [7:0] opt);
    @(posedge i_clock);
    i_stored_option_byte <= opt;
    i_reset <= 1;
    repeat (5) @(posedge i_clock);
    i_reset <= 0;
    repeat (2) @(posedge i_clock);
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d, input logic dbg);
    @(posedge i_clock);
    i_address <= a; i_write_data <= d; i_write <= 1; i_debug_access <= dbg;
    @(posedge i_clock);
    i_write <= 0; i_debug_access <= 0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge i_clock);
    i_address <= a; i_read <= 1;
    @(posedge i_clock);
    i_read <= 0;
    #1 rd_val = o_read_data;
  endtask
  // Eight key bytes; byte number bad is corrupted, none when bad is 8
  task key(input logic dbg, input int bad);
    for (int k = 0; k < 8; k++) begin
      wr(key_data_offset, i_stored_unlock_key[63-8*k -: 8] ^ {7'h00, k == bad}, dbg);
    end
    @(posedge i_clock);
    #1;
  endtask
  // Cycles between two flash ticks, after skipping the first two gaps
  task gap(input logic [7:0] ctrl, input int exp);
    int n;
    wr(timebase_ctrl_offset, ctrl, 0);
    for (int g = 0; g < 3; g++) begin
      n = 0;
      do begin @(posedge i_clock); #1 n++; end while (o_flash_tick !== 1'b1 && n < 2000);
      if (n >= 2000) begin errors++; conclude(); end
    end
    `CHK(n, exp)
  endtask
  task t_timebase;
    rst(8'hFE);
    rd(timebase_ctrl_offset);
    `CHK(rd_val, 8'h00)
    `CHK(o_op_allowed, 1'b0)
    wr(timebase_ctrl_offset, 8'h13, 0);
    #1 `CHK(o_op_allowed, 1'b1)
    @(posedge i_clock);
    i_op_request <= 1'b0;
    #1 `CHK(o_op_allowed, 1'b0)
    @(posedge i_clock);
    i_op_request <= 1'b1;
    rd(timebase_ctrl_offset);
    `CHK(rd_val, 8'h93)
    wr(timebase_ctrl_offset, 8'h00, 0);
    rd(timebase_ctrl_offset);
    `CHK(rd_val, 8'h80)
    gap(8'h02, 3);
    gap(8'h00, 1);
    gap(8'h41, 16);
    gap(8'h7F, 512);
  endtask
  task t_options;
    rst(8'hFE);
    rd(option_shadow_offset);
    `CHK(rd_val, 8'hC2)
    `CHK(o_vector_redirect_off, 1'b1)
    wr(option_shadow_offset, 8'h00, 0);
    rd(option_shadow_offset);
    `CHK(rd_val, 8'hC2)
    rd(4'hF);
    `CHK(rd_val, 8'h00)
    rst(8'h3F);
    rd(option_shadow_offset);
    `CHK(rd_val, 8'h03)
    `CHK(o_vector_redirect_off, 1'b0)
    for (int c = 0; c < 4; c++) begin
      rst({6'h00, c[1:0]});
      #1 `CHK(o_secured, (c != 2))
    end
  endtask
  task t_security;
    rst(8'h80);
    #1 `CHK(o_memory_grant, 1'b0)
    @(posedge i_clock);
    i_memory_unsecured_source <= 1'b0;
    #1 `CHK(o_memory_grant, 1'b1)
    @(posedge i_clock);
    i_memory_unsecured_source <= 1'b1;
    key(1, 8);
    `CHK(o_secured, 1'b1)
    key(0, 7);
    `CHK(o_secured, 1'b1)
    key(0, 3);
    `CHK(o_secured, 1'b1)
    key(0, 8);
    `CHK(o_secured, 1'b0)
    `CHK(o_memory_grant, 1'b1)
    rd(lock_status_offset);
    `CHK(rd_val[0], 1'b0)
    rst(8'h01);
    key(0, 8);
    `CHK(o_secured, 1'b1)
    wr(blank_pass_offset, 8'h01, 0);
    #1 `CHK(o_secured, 1'b0)
  endtask
  initial begin
    t_timebase();
    t_options();
    t_security();
    conclude();
  end
endmodule // tb
